// File: common/page_stack_defines.svh
// Offsets, field positions, reset values and sizes of the page context stack
`ifndef PAGE_STACK_DEFINES_SVH
`define PAGE_STACK_DEFINES_SVH

// Register addresses in the special function register space
`define PG_ADDR_SELECT   8'h84
`define PG_ADDR_MIDDLE   8'h85
`define PG_ADDR_BOTTOM   8'h86
`define PG_ADDR_CONTROL  8'h96

// Stack shape and register select indices
`define PG_STACK_DEPTH   3
`define PG_SEL_COUNT     4
`define PG_SEL_SELECT    0
`define PG_SEL_MIDDLE    1
`define PG_SEL_BOTTOM    2
`define PG_SEL_CONTROL   3

// Fields and reset values
`define PG_ENABLE_BIT    0
`define PG_RESET_ENTRY   8'h00
`define PG_RESET_ENABLE  1'h1
`define PG_EMPTY_ENTRY   8'h00

`endif

// File: common/page_stack_pkg.sv
// Types shared by the page context stack modules
package page_stack_pkg;
    typedef logic [7:0] page_t;
    typedef logic [3:0] reg_sel_t;
    typedef page_t [2:0] page_stack_t;

    // Whole register state of the stack block
    typedef struct packed {
        page_stack_t entry;
        logic        autoPageEnable;
        page_t       readData;
        logic        readHit;
    } ctx_state_t;
endpackage : page_stack_pkg

// File: verilog/page_reg_decode.sv
// Address decode of the page stack and page control registers
`timescale 1ns/1ps
`include "page_stack_defines.svh"
module page_reg_decode
    import page_stack_pkg::*;
(
    // Direct address from the core
    input  wire logic [7:0] addr,
    // One-hot register select
    output reg_sel_t        regSel
);
    ////////////////////////////////////////////////////////////////////////
    // Page select is deliberately not an input: these registers are global
    always_comb begin
        regSel = '0;
        if (addr == `PG_ADDR_SELECT) begin
            regSel[`PG_SEL_SELECT] = 1'h1;
        end else if (addr == `PG_ADDR_MIDDLE) begin
            regSel[`PG_SEL_MIDDLE] = 1'h1;
        end else if (addr == `PG_ADDR_BOTTOM) begin
            regSel[`PG_SEL_BOTTOM] = 1'h1;
        end else if (addr == `PG_ADDR_CONTROL) begin
            regSel[`PG_SEL_CONTROL] = 1'h1;
        end
    end
endmodule : page_reg_decode

// File: verilog/page_read_mux.sv
// Read data selection for the page stack registers
`timescale 1ns/1ps
`include "page_stack_defines.svh"
module page_read_mux
    import page_stack_pkg::*;
(
    // Register select and contents
    input  reg_sel_t        regSel,
    input  page_stack_t     entry,
    input  wire logic       autoPageEnable,
    // Selected data
    output page_t           data,
    output logic            hit
);
    ////////////////////////////////////////////////////////////////////////
    // Unselected or foreign addresses give zero and no hit
    always_comb begin
        data = '0;
        hit  = |regSel;
        for (int i = 0; i < `PG_STACK_DEPTH; i++) begin
            if (regSel[i]) begin
                data = entry[i];
            end
        end
        if (regSel[`PG_SEL_CONTROL]) begin
            data[`PG_ENABLE_BIT] = autoPageEnable;
        end
    end
endmodule : page_read_mux

// File: verilog/interrupt_page_context_stack.sv
// Page select register with three-entry context stack driven by interrupts
`timescale 1ns/1ps
`include "page_stack_defines.svh"
module interrupt_page_context_stack
    import page_stack_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    // Register access from the core
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrRdEn,
    output page_t           sfrRdData,
    output logic            sfrRdHit,
    // Interrupt sequencing from the core
    input  wire logic       intrEntry,
    input  wire logic [7:0] intrPage,
    input  wire logic       intrReturn,
    // Page used by the rest of the register decode
    output page_t           activePage,
    output logic            autoPageActive
);
    ////////////////////////////////////////////////////////////////////////
    // State and decode

    ctx_state_t ctx;
    ctx_state_t next_ctx;
    reg_sel_t   regSel;
    page_t      muxData;
    logic       muxHit;
    logic       pushNow;
    logic       popNow;

    // Address decode ignores the page, so the stack is reachable everywhere
    page_reg_decode uDecode (
        .addr   (sfrAddr),
        .regSel (regSel)
    );

    // Read data path
    page_read_mux uReadMux (
        .regSel         (regSel),
        .entry          (ctx.entry),
        .autoPageEnable (ctx.autoPageEnable),
        .data           (muxData),
        .hit            (muxHit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Stack events

    // Entry wins if the sequencer ever pulses both; it should not
    assign pushNow = intrEntry && ctx.autoPageEnable;
    assign popNow  = intrReturn && !intrEntry && ctx.autoPageEnable;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Hardware push and pop override a software entry write in the same cycle,
    // so a context switch is never half applied
    always_comb begin
        next_ctx = ctx;
        next_ctx.readHit = 1'h0;
        if (pushNow) begin
            // Each entry moves one place down; old bottom is lost
            for (int i = `PG_STACK_DEPTH - 1; i > 0; i--) begin
                next_ctx.entry[i] = ctx.entry[i - 1];
            end
            next_ctx.entry[0] = intrPage;
        end else if (popNow) begin
            // Each entry moves one place up; top is dropped
            for (int i = 0; i < `PG_STACK_DEPTH - 1; i++) begin
                next_ctx.entry[i] = ctx.entry[i + 1];
            end
            next_ctx.entry[`PG_STACK_DEPTH - 1] = `PG_EMPTY_ENTRY;
        end else if (sfrWrEn) begin
            // Only the addressed entry changes
            for (int i = 0; i < `PG_STACK_DEPTH; i++) begin
                if (regSel[i]) begin
                    next_ctx.entry[i] = sfrWrData;
                end
            end
        end
        // Control write is independent of stack events
        if (sfrWrEn && regSel[`PG_SEL_CONTROL]) begin
            next_ctx.autoPageEnable = sfrWrData[`PG_ENABLE_BIT];
        end
        // Read answered one cycle after the request
        if (sfrRdEn) begin
            next_ctx.readData = muxData;
            next_ctx.readHit  = muxHit;
        end else begin
            next_ctx.readData = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Enable comes up set so switching works without software setup
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctx                <= '0;
            ctx.entry[0]       <= `PG_RESET_ENTRY;
            ctx.entry[1]       <= `PG_RESET_ENTRY;
            ctx.entry[2]       <= `PG_RESET_ENTRY;
            ctx.autoPageEnable <= `PG_RESET_ENABLE;
        end else begin
            ctx <= next_ctx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign activePage     = ctx.entry[0];
    assign autoPageActive = ctx.autoPageEnable;
    assign sfrRdData      = ctx.readData;
    assign sfrRdHit       = ctx.readHit;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // Enabled interrupt entry
    sequence sEntry;
        intrEntry && ctx.autoPageEnable;
    endsequence

    // Enabled return with no entry beside it
    sequence sReturn;
        intrReturn && !intrEntry && ctx.autoPageEnable;
    endsequence

    // Nothing touches the stack entries this cycle
    sequence sQuiet;
        !intrEntry && !intrReturn && !sfrWrEn;
    endsequence

    // Software write to one entry with no stack event
    sequence sEntryWrite(int idx);
        sfrWrEn && regSel[idx] && !intrEntry && !intrReturn;
    endsequence

    chk_enable_after_reset: assert property (
        $rose(arst_n) |-> ctx.autoPageEnable)
        else $error("enable not set after reset");

    chk_push_middle: assert property (
        sEntry |=> ctx.entry[1] == $past(ctx.entry[0]))
        else $error("middle did not take old page on entry");

    chk_push_page: assert property (
        sEntry |=> activePage == $past(intrPage))
        else $error("page select did not take source page");

    chk_push_bottom: assert property (
        sEntry |=> ctx.entry[2] == $past(ctx.entry[1]))
        else $error("bottom did not take old middle on entry");

    chk_pop_page: assert property (
        sReturn |=> activePage == $past(ctx.entry[1]))
        else $error("page select did not take middle on return");

    chk_pop_middle: assert property (
        sReturn |=> ctx.entry[1] == $past(ctx.entry[2]))
        else $error("middle did not take bottom on return");

    chk_pop_bottom: assert property (
        sReturn |=> ctx.entry[2] == `PG_EMPTY_ENTRY)
        else $error("bottom not cleared on return");

    chk_page_write: assert property (
        sEntryWrite(`PG_SEL_SELECT) |=> activePage == $past(sfrWrData))
        else $error("page select write lost");

    chk_middle_write: assert property (
        sEntryWrite(`PG_SEL_MIDDLE) ##1 sReturn
        |=> activePage == $past(sfrWrData, 2))
        else $error("written middle not restored on return");

    chk_write_only_addressed: assert property (
        sEntryWrite(`PG_SEL_MIDDLE)
        |=> $stable(ctx.entry[0]) && $stable(ctx.entry[2]))
        else $error("middle write disturbed other entries");

    chk_quiet_hold: assert property (
        sQuiet |=> $stable(ctx.entry))
        else $error("stack moved without an event");

    chk_disabled_hold: assert property (
        (!ctx.autoPageEnable && !sfrWrEn) |=> $stable(ctx.entry))
        else $error("stack moved while switching disabled");

    chk_global_read: assert property (
        (sfrRdEn && sfrAddr == `PG_ADDR_MIDDLE)
        |=> sfrRdHit && sfrRdData == $past(ctx.entry[1]))
        else $error("middle entry not readable on this page");

    chk_control_read: assert property (
        (sfrRdEn && sfrAddr == `PG_ADDR_CONTROL)
        |=> sfrRdData == {7'h00, $past(ctx.autoPageEnable)})
        else $error("page control readback wrong");

    chk_bottom_readwrite: assert property (
        sEntryWrite(`PG_SEL_BOTTOM)
        ##1 ((sfrRdEn && sfrAddr == `PG_ADDR_BOTTOM) and sQuiet)
        |=> sfrRdData == $past(sfrWrData, 2))
        else $error("bottom entry write not read back");

endmodule : interrupt_page_context_stack

// File: test/interrupt_sequencer_model.sv
// Behavioural interrupt entry and return sequencer facing the page stack
`timescale 1ns/1ps
module interrupt_sequencer_model (
    // Clock from the bench
    input  wire logic       ref_clk,
    // Interrupt sequencing toward the stack
    output logic            intrEntry,
    output logic [7:0]      intrPage,
    output logic            intrReturn
);
    // Idle until the bench asks for a pulse
    initial begin
        intrEntry  = 1'b0;
        intrPage   = 8'h00;
        intrReturn = 1'b0;
    end
    // Waits gap cycles, then one-cycle pulses; page is garbage outside the pulse
    task automatic pulse(input logic ent, input logic ret, input logic [7:0] page,
                         input int gap);
        repeat (gap) @(negedge ref_clk);
        @(negedge ref_clk);
        intrEntry  = ent;
        intrReturn = ret;
        intrPage   = page;
        @(negedge ref_clk);
        intrEntry  = 1'b0;
        intrReturn = 1'b0;
        intrPage   = ~page;
    endtask : pulse
endmodule : interrupt_sequencer_model

// File: test/interrupt_page_context_stack_bench.sv
// Self-checking bench for the interrupt page context stack
`timescale 1ns/1ps
`include "page_stack_defines.svh"
module interrupt_page_context_stack_bench
    import page_stack_pkg::*;
;
    logic       ref_clk, arst_n, sfrWrEn, sfrRdEn, sfrRdHit, autoPageActive;
    logic       intrEntry, intrReturn;
    logic [7:0] sfrAddr, sfrWrData, intrPage;
    page_t      sfrRdData, activePage;
    int         failCount, nChecks, cycles, mSel, mMid, mBot, mEn;
    logic [31:0] seed;
    logic [7:0] addrs [4] = '{`PG_ADDR_SELECT, `PG_ADDR_MIDDLE, `PG_ADDR_BOTTOM, `PG_ADDR_CONTROL};

    interrupt_page_context_stack interrupt_page_context_stack_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
        .sfrRdHit(sfrRdHit), .intrEntry(intrEntry), .intrPage(intrPage),
        .intrReturn(intrReturn), .activePage(activePage), .autoPageActive(autoPageActive));
    interrupt_sequencer_model interrupt_sequencer_model_inst (
        .ref_clk(ref_clk), .intrEntry(intrEntry), .intrPage(intrPage),
        .intrReturn(intrReturn));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; ceiling is far above the expected run length
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failCount = failCount + 1;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers: xorshift source, compare, model-driven bus and interrupt tasks
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic results();
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks = nChecks + 1;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            failCount = failCount + 1;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfrAddr = a; sfrWrData = d; sfrWrEn = 1'b1;
        @(negedge ref_clk);
        sfrWrEn = 1'b0;
        case (a)
            `PG_ADDR_SELECT:  mSel = d;
            `PG_ADDR_MIDDLE:  mMid = d;
            `PG_ADDR_BOTTOM:  mBot = d;
            `PG_ADDR_CONTROL: mEn = d[0];
            default: ;
        endcase
        chk(activePage, 8'(mSel));
    endtask : wr
    // Read answer is registered, so it is looked at on the following falling edge
    task automatic rd(input logic [7:0] a);
        logic [8:0] e;
        case (a)
            `PG_ADDR_SELECT:  e = {1'b1, 8'(mSel)};
            `PG_ADDR_MIDDLE:  e = {1'b1, 8'(mMid)};
            `PG_ADDR_BOTTOM:  e = {1'b1, 8'(mBot)};
            `PG_ADDR_CONTROL: e = {1'b1, 7'h00, 1'(mEn)};
            default:          e = 9'h000;
        endcase
        @(negedge ref_clk);
        sfrAddr = a; sfrRdEn = 1'b1;
        @(negedge ref_clk);
        sfrRdEn = 1'b0;
        chk(sfrRdData, e[7:0]);
        chk({7'h00, sfrRdHit}, {7'h00, e[8]});
    endtask : rd
    task automatic irq(input logic ent, input logic ret, input logic [7:0] p, input int gap);
        interrupt_sequencer_model_inst.pulse(ent, ret, p, gap);
        if (mEn != 0 && ent) begin
            mBot = mMid; mMid = mSel; mSel = p;
        end else if (mEn != 0 && ret) begin
            mSel = mMid; mMid = mBot; mBot = 0;
        end
        chk(activePage, 8'(mSel));
    endtask : irq
    task automatic all();
        foreach (addrs[i]) rd(addrs[i]);
        chk(activePage, 8'(mSel));
        chk({7'h00, autoPageActive}, 8'(mEn));
    endtask : all
    task automatic rst();
        @(negedge ref_clk);
        arst_n = 1'b0;
        #5 chk(activePage, 8'h00);
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        mSel = 0; mMid = 0; mBot = 0; mEn = 1;
        all();
    endtask : rst

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: nested example, rewrites, disable, page sweep, random, re-reset
    initial begin
        {sfrAddr, sfrWrEn, sfrWrData, sfrRdEn} = '0;
        {failCount, nChecks, cycles} = '0;
        seed = 32'h9a00;
        arst_n = 1'b0;
        rst();
        wr(`PG_ADDR_SELECT, 8'h0F);
        irq(1'b1, 1'b0, 8'h02, 0); all();
        wr(`PG_ADDR_BOTTOM, 8'h33); irq(1'b1, 1'b0, 8'h00, 3); all();
        irq(1'b0, 1'b1, 8'h00, 0); all();
        wr(`PG_ADDR_MIDDLE, 8'h5A); all();
        irq(1'b0, 1'b1, 8'h00, 1); all();
        irq(1'b1, 1'b1, 8'h03, 0); all();
        rd(8'h87);
        wr(`PG_ADDR_CONTROL, 8'hFE); all();
        irq(1'b1, 1'b0, 8'h07, 0); irq(1'b0, 1'b1, 8'h00, 2); all();
        wr(`PG_ADDR_CONTROL, 8'hFF); all();
        // Back to back: middle write then a pop in the very next cycle
        fork
            wr(`PG_ADDR_MIDDLE, 8'h44);
            irq(1'b0, 1'b1, 8'h00, 1);
        join
        all();
        // Bottom write read back next cycle; expectation set first as the two overlap
        mBot = 8'h66;
        fork
            wr(`PG_ADDR_BOTTOM, 8'h66);
            begin
                @(negedge ref_clk);
                rd(`PG_ADDR_BOTTOM);
            end
        join
        foreach (addrs[i]) begin
            wr(`PG_ADDR_SELECT, (i == 3) ? 8'h0F : 8'(i));
            rd(`PG_ADDR_MIDDLE); rd(`PG_ADDR_BOTTOM); rd(`PG_ADDR_CONTROL);
        end
        repeat (300) begin
            logic [31:0] r;
            r = rnd();
            case (r[1:0])
                2'd0: wr(r[4] ? r[15:8] : addrs[r[6:5]], r[23:16]);
                2'd1: irq(1'b1, 1'b0, r[15:8], int'(r[5:4]));
                2'd2: irq(1'b0, 1'b1, r[15:8], int'(r[5:4]));
                default: rd(r[4] ? r[15:8] : addrs[r[6:5]]);
            endcase
        end
        all();
        rst();
        results();
    end
endmodule : interrupt_page_context_stack_bench
